// ---- rtl/legacy_pkg.sv ----
/*
 * shared constants and types of the legacy dma, timer and interrupt block.
 * assumes one core clock; all users refer to names as legacy_pkg::name.
 */
package legacy_pkg;
  // ---------------------------------------------------------------
  // dma
  // ---------------------------------------------------------------
  localparam int          NUM_CH       = 8;
  localparam logic [2:0]  CASCADE_CH   = 3'h4;
  localparam logic [7:0]  USABLE_CH    = 8'hef;
  localparam int          MAX_FAST     = 2;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          FIFO_WIDTH   = 32;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
  typedef enum logic [1:0] {
    XFER_SINGLE,
    XFER_DEMAND,
    XFER_VERIFY,
    XFER_INCR
  } xfer_mode_t;
  // ---------------------------------------------------------------
  // timer and interrupts
  // ---------------------------------------------------------------
  localparam int          NUM_TMR      = 3;
  localparam real         OSC_MHZ      = 14.31818;
  localparam logic [15:0] TMR_RESET    = 16'h0000;
  localparam int          NUM_IRQ      = 16;
  localparam logic [15:0] IRQ_INTERNAL = 16'h0005;
  localparam logic [15:0] IRQ_CASC_BIT = 16'h0004;
  localparam logic [3:0]  SER_LAST     = 4'hf;
endpackage

// ---- rtl/fifo_if.sv ----
/*
 * carrier between the block top and its data fifo.
 * assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface fifo_if #(
  parameter int W = 32
) ();
  logic         wvalid;
  logic         wready;
  logic [W-1:0] wdata;
  logic         rvalid;
  logic         rready;
  logic [W-1:0] rdata;
  modport user (output wvalid, wdata, rready, input wready, rvalid, rdata);
  modport store (input wvalid, wdata, rready, output wready, rvalid, rdata);
endinterface

// ---- rtl/xfer_fifo.sv ----
/*
 * small flip-flop fifo on the dma data path.
 * assumes depth is a power of two; reset is synchronous, active high.
 */
`timescale 1ns/1ps
module xfer_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  fifo_if.store     f
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_st_t;
  fifo_st_t s;
  fifo_st_t next_s;
  logic     push;
  logic     pop;

  assign f.wready = (s.cnt != (AW+1)'(D));
  assign f.rvalid = (s.cnt != '0);
  assign f.rdata  = s.mem[s.rp];
  assign push     = f.wvalid & f.wready;
  assign pop      = f.rvalid & f.rready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = f.wdata;
      next_s.wp        = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  property p_fifo_bound;
    @(posedge core_clk_i) disable iff (rst_i)
      s.cnt <= (AW+1)'(D);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo count beyond depth");

  property p_fifo_full_stall;
    @(posedge core_clk_i) disable iff (rst_i)
      (!f.wready && !f.rready) |=> !f.wready;
  endproperty
  a_fifo_full_stall: assert property (p_fifo_full_stall)
    else $error("full fifo freed without a read");
endmodule

// ---- rtl/legacy_dma_timer_pic_block.sv ----
/*
 * legacy dma controller, interval timers and interrupt controller.
 * assumes configuration arrives on plain ports from core-clock logic;
 * request pins, irq pins, serial irq and the oscillator are asynchronous.
 */
`timescale 1ns/1ps
module legacy_dma_timer_pic_block (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cfg_we_i,
  input  wire logic [2:0]             cfg_ch_i,
  input  wire logic                   cfg_en_i,
  input  wire logic                   cfg_fast_i,
  input  wire legacy_pkg::xfer_mode_t cfg_mode_i,
  input  wire logic [15:0]            cfg_count_i,
  input  wire logic [15:0]            cfg_addr_i,
  output logic                        cfg_refused_o,
  input  wire logic [7:0]             ldrq_n_i,
  input  wire logic                   cascade_req_i,
  output logic                        cascade_grant_o,
  input  wire logic [15:0]            lad_data_i,
  input  wire logic                   lad_valid_i,
  output logic                        lad_ready_o,
  output logic                        dma_active_o,
  output logic [2:0]                  dma_ch_o,
  output logic                        dma_wide_o,
  output logic                        dma_fast_o,
  output logic                        tc_o,
  output logic [15:0]                 mem_data_o,
  output logic [15:0]                 mem_addr_o,
  output logic                        mem_valid_o,
  input  wire logic                   mem_ready_i,
  input  wire logic                   osc_i,
  input  wire logic                   tmr_load_i,
  input  wire logic [1:0]             tmr_sel_i,
  input  wire logic [15:0]            tmr_value_i,
  output logic                        tick1_o,
  output logic                        speaker_o,
  input  wire logic [15:0]            irq_i,
  input  wire logic                   serirq_i,
  input  wire logic                   serirq_start_i,
  input  wire logic [15:0]            irq_mask_i,
  input  wire logic                   irq_ack_i,
  output logic                        intr_o,
  output logic [3:0]                  intr_vec_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DMA_IDLE, DMA_XFER, DMA_CASC} dma_st_t;
  typedef struct packed {
    logic [1:0][7:0]             ldrq_s;
    logic [1:0][15:0]            irq_s;
    logic [1:0]                  ser_s;
    logic [1:0]                  start_s;
    logic [1:0]                  osc_s;
    logic                        osc_d;
    logic                        start_d;
    logic [7:0]                  en;
    logic [7:0]                  fast;
    legacy_pkg::xfer_mode_t [7:0] mode;
    logic [7:0][15:0]            count;
    logic [7:0][15:0]            addr;
    dma_st_t                     st;
    logic [2:0]                  ch;
    logic                        tc;
    logic                        refused;
    logic [2:0][15:0]            tcnt;
    logic [2:0][15:0]            treload;
    logic                        speaker;
    logic                        tick1;
    logic [15:0]                 src_d;
    logic [15:0]                 ser_shift;
    logic [15:0]                 ser_lvl;
    logic [15:0]                 pend;
    logic [3:0]                  slot;
    logic                        ser_busy;
  } st_t;
  st_t s;
  st_t next_s;

  fifo_if #(.W(legacy_pkg::FIFO_WIDTH)) f ();

  // lowest set bit; bit 4 flags an empty vector
  function automatic logic [4:0] first16(input logic [15:0] v);
    first16 = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first16 = 5'(i);
      end
    end
  endfunction

  function automatic logic [3:0] ones8(input logic [7:0] v);
    ones8 = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones8 = ones8 + 4'(v[i]);
    end
  endfunction

  logic [7:0]  req;
  logic [4:0]  pick;
  logic        xfer_ok;
  logic        verify;
  logic        fire;
  logic [15:0] eff;
  logic [4:0]  mfirst;
  logic [4:0]  sfirst;
  logic [3:0]  vec;
  logic        tick;
  logic [2:0]  term;

  assign req     = ~s.ldrq_s[1] & s.en & legacy_pkg::USABLE_CH;
  assign pick    = first16({8'h00, req});
  assign verify  = (s.mode[s.ch] == legacy_pkg::XFER_VERIFY);
  assign xfer_ok = (s.st == DMA_XFER) & req[s.ch];
  assign fire    = xfer_ok & lad_valid_i & (verify | f.wready);

  assign f.wvalid = xfer_ok & lad_valid_i & ~verify;
  // byte channels clear the high byte
  assign f.wdata  = {s.addr[s.ch],
                     s.ch[2] ? lad_data_i : {8'h00, lad_data_i[7:0]}};
  assign f.rready = mem_ready_i;

  assign eff    = s.pend & ~irq_mask_i & ~legacy_pkg::IRQ_CASC_BIT;
  assign sfirst = first16({8'h00, eff[15:8]});
  assign mfirst = first16({8'h00, eff[7:3], |eff[15:8], eff[1:0]});
  assign vec    = (mfirst == 5'h02) ? (4'h8 + sfirst[3:0]) : mfirst[3:0];
  assign tick   = s.osc_s[1] & ~s.osc_d;

  always_comb begin
    logic [15:0] src;
    logic [15:0] shift;
    logic [15:0] clr;
    next_s = s;
    src    = '0;
    shift  = s.ser_shift;
    clr    = '0;
    term   = '0;
    // -------------------------------------------------------------
    // synchronisers
    // -------------------------------------------------------------
    next_s.ldrq_s  = {s.ldrq_s[0], ldrq_n_i};
    next_s.irq_s   = {s.irq_s[0], irq_i};
    next_s.ser_s   = {s.ser_s[0], serirq_i};
    next_s.start_s = {s.start_s[0], serirq_start_i};
    next_s.osc_s   = {s.osc_s[0], osc_i};
    next_s.osc_d   = s.osc_s[1];
    next_s.start_d = s.start_s[1];
    next_s.tc      = 1'b0;
    next_s.refused = 1'b0;
    // -------------------------------------------------------------
    // dma sequencing
    // -------------------------------------------------------------
    case (s.st)
      DMA_IDLE: begin
        // cascade owns the bus when asked
        if (cascade_req_i) begin
          next_s.st = DMA_CASC;
        end else if (!pick[4]) begin
          next_s.ch = pick[2:0];
          next_s.st = DMA_XFER;
        end
      end
      DMA_CASC: begin
        if (!cascade_req_i) begin
          next_s.st = DMA_IDLE;
        end
      end
      DMA_XFER: begin
        if (!xfer_ok) begin
          next_s.st = DMA_IDLE;
        end else if (fire) begin
          // one count per word or byte moved
          next_s.count[s.ch] = s.count[s.ch] - 16'h0001;
          if (s.mode[s.ch] == legacy_pkg::XFER_INCR) begin
            next_s.addr[s.ch] = s.addr[s.ch] + (s.ch[2] ?
              legacy_pkg::STEP_WORD : legacy_pkg::STEP_BYTE);
          end
          if (s.count[s.ch] == 16'h0001) begin
            next_s.tc     = 1'b1;
            next_s.en[s.ch] = 1'b0;
            next_s.st     = DMA_IDLE;
          end else if (s.mode[s.ch] == legacy_pkg::XFER_SINGLE) begin
            next_s.st = DMA_IDLE;
          end
        end
      end
      default: begin
        next_s.st = DMA_IDLE;
      end
    endcase
    if (cfg_we_i) begin
      if (cfg_ch_i == legacy_pkg::CASCADE_CH) begin
        next_s.refused = 1'b1;
      end else if (cfg_fast_i && !s.fast[cfg_ch_i] &&
                   ones8(s.fast) >= 4'(legacy_pkg::MAX_FAST)) begin
        next_s.refused = 1'b1;
      end else begin
        next_s.en[cfg_ch_i]    = cfg_en_i & (cfg_count_i != 16'h0000);
        next_s.fast[cfg_ch_i]  = cfg_fast_i;
        next_s.mode[cfg_ch_i]  = cfg_mode_i;
        next_s.count[cfg_ch_i] = cfg_count_i;
        next_s.addr[cfg_ch_i]  = cfg_addr_i;
      end
    end
    // -------------------------------------------------------------
    // interval counters
    // -------------------------------------------------------------
    // three reload counters
    for (int k = 0; k < legacy_pkg::NUM_TMR; k++) begin
      if (tmr_load_i && tmr_sel_i == 2'(k)) begin
        next_s.treload[k] = tmr_value_i;
        next_s.tcnt[k]    = tmr_value_i;
      end else if (tick) begin
        if (s.tcnt[k] <= 16'h0001) begin
          next_s.tcnt[k] = s.treload[k];
          term[k]        = 1'b1;
        end else begin
          next_s.tcnt[k] = s.tcnt[k] - 16'h0001;
        end
      end
    end
    next_s.tick1 = term[1];
    if (term[2]) begin
      next_s.speaker = ~s.speaker;
    end
    // -------------------------------------------------------------
    // serial interrupt frame
    // -------------------------------------------------------------
    // one slot per cycle after start
    if (s.start_s[1] && !s.start_d) begin
      next_s.ser_busy = 1'b1;
      next_s.slot     = 4'h0;
    end else if (s.ser_busy) begin
      shift[s.slot]    = ~s.ser_s[1];
      next_s.ser_shift = shift;
      next_s.slot      = s.slot + 4'h1;
      if (s.slot == legacy_pkg::SER_LAST) begin
        next_s.ser_busy = 1'b0;
        next_s.ser_lvl  = shift & ~legacy_pkg::IRQ_CASC_BIT;
      end
    end
    // -------------------------------------------------------------
    // interrupt capture, set wins over acknowledge
    // -------------------------------------------------------------
    // timer event from synchronised tick
    src        = s.irq_s[1] & ~legacy_pkg::IRQ_INTERNAL;
    src[0]     = term[0];
    next_s.src_d = src;
    if (irq_ack_i && intr_o) begin
      clr[vec] = 1'b1;
    end
    next_s.pend = (s.pend & ~clr) | (src & ~s.src_d) |
                  (next_s.ser_lvl & ~s.ser_lvl);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  xfer_fifo #(
    .W(legacy_pkg::FIFO_WIDTH),
    .D(legacy_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i     (rst_i),
    .f         (f)
  );

  assign lad_ready_o     = fire;
  assign cfg_refused_o   = s.refused;
  assign cascade_grant_o = (s.st == DMA_CASC);
  assign dma_active_o    = (s.st == DMA_XFER);
  assign dma_ch_o        = s.ch;
  assign dma_wide_o      = s.ch[2];
  assign dma_fast_o      = s.fast[s.ch];
  assign tc_o            = s.tc;
  assign mem_valid_o     = f.rvalid;
  assign mem_data_o      = f.rdata[15:0];
  assign mem_addr_o      = f.rdata[31:16];
  assign tick1_o         = s.tick1;
  assign speaker_o       = s.speaker;
  assign intr_o          = (eff != 16'h0000);
  assign intr_vec_o      = vec;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_fast_limit;
    ones8(s.fast) <= 4'h2;
  endproperty
  a_fast_limit: assert property (p_fast_limit)
    else $error("more than two fast channels");

  property p_no_ch4;
    dma_active_o |-> (dma_ch_o != 3'h4) && !s.en[4];
  endproperty
  a_no_ch4: assert property (p_no_ch4)
    else $error("channel four transferring");

  property p_byte_lane;
    (f.wvalid && !s.ch[2]) |-> (f.wdata[15:8] == 8'h00);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte channel pushed a high byte");

  property p_count_step;
    (fire && !cfg_we_i) |=>
      s.count[$past(s.ch)] == $past(s.count[s.ch]) - 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count not stepped by one");

  property p_single;
    (fire && s.mode[s.ch] == legacy_pkg::XFER_SINGLE) |=> !dma_active_o;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode kept the channel");

  property p_osc_only;
    (!tick && !tmr_load_i) |=> $stable(s.tcnt);
  endproperty
  a_osc_only: assert property (p_osc_only)
    else $error("counter moved without oscillator edge");

  property p_tmr_irq;
    (tick && s.tcnt[0] <= 16'h0001 && !tmr_load_i) |=> s.pend[0];
  endproperty
  a_tmr_irq: assert property (p_tmr_irq)
    else $error("timer terminal did not set irq0");

  property p_irq_pin;
    (s.irq_s[1][1] && !s.src_d[1] && !irq_mask_i[1]) |=> ##[0:1] intr_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("unmasked edge raised no interrupt");

  property p_serial;
    (s.ser_busy && s.slot == 4'hf && !s.ser_s[1] && !s.ser_lvl[15]) |=>
      s.pend[15];
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial slot did not set pending");
endmodule

// ---- tb/lpc_periph_model.sv ----
/*
 * far-side model: one peripheral that requests dma and offers data words.
 * assumes the core clock and the synchronous high reset of the block.
 */
`timescale 1ns/1ps
module lpc_periph_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic [2:0]  ch_i,
  input  wire logic [15:0] words_i,
  input  wire logic [15:0] base_i,
  input  wire logic        lad_ready_i,
  output logic      [7:0]  ldrq_n_o,
  output logic      [15:0] lad_data_o,
  output logic             lad_valid_o,
  output logic      [15:0] sent_o
);
  logic busy;
  logic took;
  logic more;

  assign took = lad_valid_o && lad_ready_i;
  assign more = (sent_o + 16'h0001) < words_i;
  assign ldrq_n_o = busy ? ~(8'h01 << ch_i) : 8'hff;

  // offer held until taken; slow mode leaves a gap after each take
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy        <= 1'b0;
      lad_valid_o <= 1'b0;
      sent_o      <= 16'h0000;
      lad_data_o  <= 16'h0000;
    end else if (start_i) begin
      busy        <= 1'b1;
      sent_o      <= 16'h0000;
      lad_valid_o <= 1'b1;
      lad_data_o  <= base_i;
    end else if (busy) begin
      if (took) begin
        sent_o      <= sent_o + 16'h0001;
        lad_data_o  <= base_i + sent_o + 16'h0001;
        lad_valid_o <= more && !slow_i;
        busy        <= more;
      end else begin
        lad_valid_o <= 1'b1;
      end
    end else begin
      // released data lines must not look like a stale value
      lad_data_o <= ~lad_data_o;
    end
  end
endmodule

// ---- tb/legacy_dma_timer_pic_block_tb.sv ----
/*
 * self-checking bench of the legacy dma, timer and interrupt block.
 * assumes the peripheral model and the design files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    tests_run++; \
    if ((a) !== (e)) begin \
      fails++; \
      $display("BAD %0t got %0h want %0h", $time, (a), (e)); \
    end \
  end
module legacy_dma_timer_pic_block_tb;
  logic core_clk_i, rst_i, cfg_we_i, cfg_en_i, cfg_fast_i, cfg_refused_o;
  logic [2:0]  cfg_ch_i, p_ch, dma_ch_o;
  logic [15:0] cfg_count_i, cfg_addr_i, p_words, p_base, p_sent;
  legacy_pkg::xfer_mode_t cfg_mode_i;
  logic [7:0]  ldrq_n;
  logic [15:0] lad_data, mem_data_o, mem_addr_o, tmr_value_i;
  logic [15:0] irq_i, irq_mask_i;
  logic lad_valid, lad_ready, p_start, p_slow, cascade_req_i, grant;
  logic dma_active_o, dma_wide_o, dma_fast_o, tc_o, mem_valid_o;
  logic mem_ready_i, osc_i, tmr_load_i, tick1_o, speaker_o, serirq_i;
  logic serirq_start_i, irq_ack_i, intr_o, act_d, spk_d, last_w, last_f;
  logic [1:0]  tmr_sel_i;
  logic [3:0]  intr_vec_o;
  logic [31:0] q[$];
  int fails, tests_run, cyc, tcs, rises, ticks, toggles, stalled;

  legacy_dma_timer_pic_block uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cfg_we_i(cfg_we_i), .cfg_ch_i(cfg_ch_i), .cfg_en_i(cfg_en_i),
    .cfg_fast_i(cfg_fast_i), .cfg_mode_i(cfg_mode_i),
    .cfg_count_i(cfg_count_i), .cfg_addr_i(cfg_addr_i),
    .cfg_refused_o(cfg_refused_o), .ldrq_n_i(ldrq_n),
    .cascade_req_i(cascade_req_i), .cascade_grant_o(grant),
    .lad_data_i(lad_data), .lad_valid_i(lad_valid), .lad_ready_o(lad_ready),
    .dma_active_o(dma_active_o), .dma_ch_o(dma_ch_o),
    .dma_wide_o(dma_wide_o), .dma_fast_o(dma_fast_o), .tc_o(tc_o),
    .mem_data_o(mem_data_o), .mem_addr_o(mem_addr_o),
    .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i), .osc_i(osc_i),
    .tmr_load_i(tmr_load_i), .tmr_sel_i(tmr_sel_i),
    .tmr_value_i(tmr_value_i), .tick1_o(tick1_o), .speaker_o(speaker_o),
    .irq_i(irq_i), .serirq_i(serirq_i), .serirq_start_i(serirq_start_i),
    .irq_mask_i(irq_mask_i), .irq_ack_i(irq_ack_i), .intr_o(intr_o),
    .intr_vec_o(intr_vec_o));

  lpc_periph_model periph (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .start_i(p_start), .slow_i(p_slow), .ch_i(p_ch), .words_i(p_words),
    .base_i(p_base), .lad_ready_i(lad_ready), .ldrq_n_o(ldrq_n),
    .lad_data_o(lad_data), .lad_valid_o(lad_valid), .sent_o(p_sent));

  // ---------------------------------------------------------------
  // clock, monitor, timeout
  // ---------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (mem_valid_o && mem_ready_i) q.push_back({mem_addr_o, mem_data_o});
    if (tc_o) tcs++;
    if (dma_active_o && !act_d) rises++;
    if (tick1_o) ticks++;
    if (speaker_o !== spk_d) toggles++;
    if (dma_active_o) last_w = dma_wide_o;
    if (dma_active_o) last_f = dma_fast_o;
    act_d = dma_active_o;
    spk_d = speaker_o;
    cyc++;
    if (cyc == 6000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // shared drivers
  // ---------------------------------------------------------------
  task automatic cfg(input logic [2:0] ch, input logic f,
      input legacy_pkg::xfer_mode_t m, input logic [15:0] n,
      input logic [15:0] a, input logic rexp);
    @(posedge core_clk_i);
    cfg_we_i    <= 1'b1;
    cfg_ch_i    <= ch;
    cfg_fast_i  <= f;
    cfg_mode_i  <= m;
    cfg_count_i <= n;
    cfg_addr_i  <= a;
    @(posedge core_clk_i);
    cfg_we_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(cfg_refused_o, rexp)
  endtask

  // sink stalls first so the fifo fills, then drains
  task automatic run_dma(input logic [2:0] ch, input logic [15:0] w,
      input logic sl, input logic [15:0] b);
    int k;
    @(negedge core_clk_i);
    q.delete();
    tcs   = 0;
    rises = 0;
    @(posedge core_clk_i);
    p_ch    <= ch;
    p_words <= w;
    p_slow  <= sl;
    p_base  <= b;
    p_start <= 1'b1;
    @(posedge core_clk_i);
    p_start <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    stalled = p_sent;
    mem_ready_i <= 1'b1;
    k = 0;
    while (p_sent < w && k < 200) begin
      @(posedge core_clk_i);
      k++;
    end
    repeat (12) @(posedge core_clk_i);
    mem_ready_i <= 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic ack();
    @(posedge core_clk_i);
    irq_ack_i <= 1'b1;
    @(posedge core_clk_i);
    irq_ack_i <= 1'b0;
    @(negedge core_clk_i);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_cfg();
    cfg(3'h4, 1'b0, legacy_pkg::XFER_SINGLE, 16'h0003, 16'h0000,
        1'b1);
    cfg(3'h0, 1'b1, legacy_pkg::XFER_SINGLE, 16'h0002, 16'h0020,
        1'b0);
    cfg(3'h1, 1'b1, legacy_pkg::XFER_INCR, 16'h0005, 16'h0010,
        1'b0);
    cfg(3'h2, 1'b1, legacy_pkg::XFER_VERIFY, 16'h0002, 16'h0000,
        1'b1);
    cfg(3'h2, 1'b0, legacy_pkg::XFER_VERIFY, 16'h0002, 16'h0000,
        1'b0);
  endtask

  task automatic s_byte();
    run_dma(3'h1, 16'h0005, 1'b0, 16'ha5c3);
    `CHK(stalled, legacy_pkg::FIFO_DEPTH)
    `CHK(q.size(), 5)
    for (int i = 0; i < 5; i++) begin
      `CHK(q[i], {16'h0010 + 16'(i), 8'h00, 8'hc3 + 8'(i)})
    end
    `CHK(tcs, 1)
    `CHK(last_w, 1'b0)
    `CHK(last_f, 1'b1)
    `CHK(dma_ch_o, 3'h1)
  endtask

  task automatic s_word();
    cfg(3'h5, 1'b0, legacy_pkg::XFER_INCR, 16'h0002, 16'h0100,
        1'b0);
    run_dma(3'h5, 16'h0002, 1'b1, 16'h1234);
    `CHK(q.size(), 2)
    `CHK(q[0], 32'h0100_1234)
    `CHK(q[1], 32'h0102_1235)
    `CHK(last_w, 1'b1)
    `CHK(tcs, 1)
    `CHK(dma_ch_o, 3'h5)
  endtask

  task automatic s_modes();
    run_dma(3'h0, 16'h0002, 1'b0, 16'h0041);
    `CHK(rises, 2)
    `CHK(q.size(), 2)
    `CHK(q[1], 32'h0020_0042)
    run_dma(3'h2, 16'h0002, 1'b0, 16'h0007);
    `CHK(q.size(), 0)
    `CHK(tcs, 1)
    `CHK(last_f, 1'b0)
    cfg(3'h6, 1'b0, legacy_pkg::XFER_DEMAND, 16'h0002, 16'h0200,
        1'b0);
    run_dma(3'h6, 16'h0002, 1'b0, 16'h5000);
    `CHK(rises, 1)
    `CHK(q[0], 32'h0200_5000)
    `CHK(q[1], 32'h0200_5001)
  endtask

  task automatic s_cascade();
    int k;
    @(posedge core_clk_i);
    cascade_req_i <= 1'b1;
    k = 0;
    while (grant !== 1'b1 && k < 10) begin
      @(negedge core_clk_i);
      k++;
    end
    `CHK(grant, 1'b1)
    @(posedge core_clk_i);
    cascade_req_i <= 1'b0;
    repeat (10) @(negedge core_clk_i);
    `CHK(grant, 1'b0)
  endtask

  task automatic s_timer();
    @(posedge core_clk_i);
    tmr_load_i  <= 1'b1;
    tmr_sel_i   <= 2'h1;
    tmr_value_i <= 16'h0002;
    @(posedge core_clk_i);
    tmr_sel_i   <= 2'h2;
    tmr_value_i <= 16'h0003;
    @(posedge core_clk_i);
    tmr_load_i <= 1'b0;
    @(negedge core_clk_i);
    ticks   = 0;
    toggles = 0;
    // oscillator kept well below half the core rate to avoid aliasing
    repeat (9) begin
      repeat (4) @(posedge core_clk_i);
      osc_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      osc_i <= 1'b0;
    end
    repeat (10) @(negedge core_clk_i);
    `CHK(ticks, 4)
    `CHK(toggles, 3)
    @(posedge core_clk_i);
    irq_mask_i <= 16'hfffe;
    repeat (3) @(negedge core_clk_i);
    `CHK(intr_o, 1'b1)
    `CHK(intr_vec_o, 4'h0)
    ack();
    `CHK(intr_o, 1'b0)
    @(posedge core_clk_i);
    irq_mask_i <= 16'h0001;
  endtask

  task automatic s_irq();
    @(posedge core_clk_i);
    irq_i <= 16'h010e;
    repeat (8) @(negedge core_clk_i);
    `CHK(intr_vec_o, 4'h1)
    ack();
    `CHK(intr_vec_o, 4'h8)
    ack();
    `CHK(intr_vec_o, 4'h3)
    ack();
    `CHK(intr_o, 1'b0)
    @(posedge core_clk_i);
    irq_i <= 16'h0000;
  endtask

  task automatic s_serial();
    @(posedge core_clk_i);
    irq_mask_i     <= 16'hfdff;
    serirq_i       <= 1'b0;
    serirq_start_i <= 1'b1;
    repeat (30) @(negedge core_clk_i);
    `CHK(intr_o, 1'b1)
    `CHK(intr_vec_o, 4'h9)
    @(posedge core_clk_i);
    serirq_i       <= 1'b1;
    serirq_start_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {fails, tests_run, cyc, tcs, rises, ticks, toggles} = '0;
    {act_d, spk_d, last_w, last_f} = '0;
    rst_i = 1'b1;
    {cfg_we_i, cfg_fast_i, p_start, p_slow, cascade_req_i} = '0;
    {mem_ready_i, osc_i, tmr_load_i, serirq_start_i, irq_ack_i} = '0;
    cfg_en_i = 1'b1;
    serirq_i = 1'b1;
    {cfg_ch_i, p_ch, tmr_sel_i} = '0;
    cfg_mode_i = legacy_pkg::XFER_SINGLE;
    {cfg_count_i, cfg_addr_i, p_words, p_base, tmr_value_i, irq_i} = '0;
    irq_mask_i = 16'h0001;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    s_cfg();
    s_byte();
    s_word();
    s_modes();
    s_cascade();
    s_timer();
    s_irq();
    s_serial();
    final_report();
  end
endmodule
